// ---- rtl/sbspc_port_ctrl.sv ----
// synchronous port control of a pipelined double-late-write burst sram
// assumes all inputs synchronous to sys_clk; memory array held here
//
// Notes on behaviour
// - load_advance_n high steps the burst counter and uses its address.
// - read/write input is ignored while load_advance_n is high.
// - load_advance_n low captures a new external address.
// - cycle type comes from rw_n at load only: low writes, high reads.
// - only lanes with low write enable are written; all low writes all.
// - data bus is eight lanes of eight data bits plus parity.
// - burst order select high gives interleaved, low gives linear.
// - each programmable select takes its polarity from its own polarity strap.
// - echo clocks copy the main clock, true and inverted forms.
// - address bits one and zero at load seed the burst counter.
// - write data is captured on the third edge after the command.
// - read data appears from the output register one edge later.
`timescale 1ns/1ps
module sbspc_port_ctrl
  import sbspc_pkg::*;
#(
  parameter int DEPTH_W = ADDR_W
)(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // command pins
  input  wire logic [DEPTH_W-1:0]   addr,
  input  wire logic                 load_advance_n,
  input  wire logic                 rw_n,
  input  wire logic                 primary_select_n,
  input  wire logic                 prog_select_two,
  input  wire logic                 prog_select_three,
  input  wire logic [LANES-1:0]     lane_write_n,
  // static straps
  input  wire logic                 select_two_polarity,
  input  wire logic                 select_three_polarity,
  input  wire logic                 burst_order_sel_n,
  // data pins, split three ways
  input  wire logic [DATA_W-1:0]    data_in,
  output logic      [DATA_W-1:0]    data_out,
  output logic                      data_oe,
  // echo clocks
  output logic                      echo_clock_true_one,
  output logic                      echo_clock_true_two,
  output logic                      echo_clock_inv_one,
  output logic                      echo_clock_inv_two,
  output logic                      echo_oe
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]  mem [0:(1<<DEPTH_W)-1];
  logic [DEPTH_W-BURST_W-1:0] upper_q;
  sbspc_op_t          op_q;           // cycle type of the current burst
  logic               bank_ok_q;      // programmable selects at load
  sbspc_op_t          acc_op;         // operation of this edge
  logic [DEPTH_W-1:0] acc_addr;
  logic               load;
  logic               sel_two;
  logic               sel_three;
  logic               bank_sel;
  logic               rd_v_q;         // read taken at the last edge
  logic [DEPTH_W-1:0] rd_a_q;         // its address
  logic               echo_sel_q;     // echo enable, first stage
  sbspc_burst_if      bif ();

  // write pipeline: address and enables wait for the late data
  logic [WR_DATA_EDGE-1:0]  wr_v_q;
  logic [DEPTH_W-1:0]       wr_a_q  [WR_DATA_EDGE];
  logic [LANES-1:0]         wr_be_q [WR_DATA_EDGE];

  // ----------------------------------------------------------------
  // select decode
  // ----------------------------------------------------------------
  function automatic logic prog_sel(input logic pin, input logic pol);
    return pol ? pin : ~pin;
  endfunction : prog_sel

  assign sel_two   = prog_sel(prog_select_two, select_two_polarity);
  assign sel_three = prog_sel(prog_select_three, select_three_polarity);
  assign bank_sel  = sel_two & sel_three;
  assign load      = ~load_advance_n;

  // ----------------------------------------------------------------
  // burst generator
  // ----------------------------------------------------------------
  assign bif.load    = load;
  assign bif.advance = load_advance_n;
  assign bif.linear  = ~burst_order_sel_n;
  assign bif.start   = addr[BURST_W-1:0];

  sbspc_burst_gen u_burst (
    .sys_clk (sys_clk),
    .srst    (srst),
    .bif     (bif)
  );

  // ----------------------------------------------------------------
  // cycle decode for this edge
  // ----------------------------------------------------------------
  always_comb begin
    if (load) begin
      acc_addr = addr;
      if (primary_select_n | ~bank_sel) begin
        acc_op = SBSPC_IDLE;
      end else if (rw_n) begin
        acc_op = SBSPC_READ;
      end else begin
        acc_op = SBSPC_WRITE;
      end
    end else begin
      // rw_n not looked at here; burst keeps its type
      acc_addr = {upper_q, bif.addr};
      acc_op   = op_q;
    end
  end

  // latch upper bits and cycle type at each load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upper_q   <= '0;
      op_q      <= SBSPC_IDLE;
      bank_ok_q <= 1'b0;
    end else if (load) begin
      upper_q   <= addr[DEPTH_W-1:BURST_W];
      op_q      <= acc_op;
      bank_ok_q <= bank_sel;
    end
  end

  // ----------------------------------------------------------------
  // double late write pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_v_q <= '0;
    end else begin
      wr_v_q <= {wr_v_q[WR_DATA_EDGE-2:0], acc_op == SBSPC_WRITE};
    end
  end

  // enables ride with the address
  always_ff @(posedge sys_clk) begin
    wr_a_q[0]  <= acc_addr;
    wr_be_q[0] <= lane_write_n;
    for (int i = 1; i < WR_DATA_EDGE; i++) begin
      wr_a_q[i]  <= wr_a_q[i-1];
      wr_be_q[i] <= wr_be_q[i-1];
    end
  end

  // lane masked store; one process owns the whole array, since a
  // computed index would make per-lane processes collide on it
  always_ff @(posedge sys_clk) begin
    for (int ln = 0; ln < LANES; ln++) begin
      if (wr_v_q[WR_DATA_EDGE-1] & ~wr_be_q[WR_DATA_EDGE-1][ln]) begin
        mem[wr_a_q[WR_DATA_EDGE-1]][ln*LANE_BITS +: LANE_BITS]
          <= data_in[ln*LANE_BITS +: LANE_BITS];
      end
    end
  end

  // ----------------------------------------------------------------
  // pipelined read output register
  // ----------------------------------------------------------------
  // address stage: the command edge only latches the read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_v_q <= 1'b0;
    end else begin
      rd_v_q <= (acc_op == SBSPC_READ);
    end
  end

  // read address rides with the valid bit, no reset needed
  always_ff @(posedge sys_clk) begin
    rd_a_q <= acc_addr;
  end

  // output register: data reaches the pins one edge after the command
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= rd_v_q;
      if (rd_v_q) begin
        data_out <= mem[rd_a_q];
      end
    end
  end

  // ----------------------------------------------------------------
  // echo clocks
  // ----------------------------------------------------------------
  // a real part uses a delayed clock; here the enable follows the bank
  // deselect through the same two stages as read data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      echo_sel_q <= 1'b0;
      echo_oe    <= 1'b0;
    end else begin
      echo_sel_q <= load ? bank_sel : bank_ok_q;
      echo_oe    <= echo_sel_q;
    end
  end

  assign echo_clock_true_one = sys_clk;
  assign echo_clock_true_two = sys_clk;
  assign echo_clock_inv_one  = ~sys_clk;
  assign echo_clock_inv_two  = ~sys_clk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  burst_keeps_type_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    load_advance_n |-> acc_op == op_q)
    else $error("burst changed cycle type");

  load_type_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (load & ~primary_select_n & bank_sel) |->
      acc_op == (rw_n ? SBSPC_READ : SBSPC_WRITE))
    else $error("wrong cycle type at load");

  upper_held_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    load ##1 load_advance_n |->
      acc_addr[DEPTH_W-1:BURST_W] == $past(addr[DEPTH_W-1:BURST_W]))
    else $error("upper address moved in burst");

  burst_step_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (load & ~burst_order_sel_n) ##1 (load_advance_n & ~burst_order_sel_n)
      |-> acc_addr[1:0] == $past(addr[1:0]) + 2'h1)
    else $error("linear burst step wrong");

  interleave_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (load & burst_order_sel_n) ##1 (load_advance_n & burst_order_sel_n)
      |-> acc_addr[1:0] == ($past(addr[1:0]) ^ 2'h1))
    else $error("interleaved burst step wrong");

  write_late_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    acc_op == SBSPC_WRITE |-> ##3 wr_v_q[WR_DATA_EDGE-1])
    else $error("write data edge not third");

  read_next_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    acc_op == SBSPC_READ |-> ##2 data_oe)
    else $error("read data not out next edge");

  select_pol_a: assert property (
    @(posedge sys_clk) disable iff (srst)
    (load & (prog_select_two != select_two_polarity)) |->
      acc_op == SBSPC_IDLE)
    else $error("programmable select polarity wrong");

endmodule : sbspc_port_ctrl

// ---- common/sbspc_pkg.sv ----
// package for the synchronous burst sram port control block
// assumes one system clock; all widths and pipeline depths live here
package sbspc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int LANES      = 8;
  localparam int LANE_BITS  = 9;            // eight data bits plus parity
  localparam int DATA_W     = LANES * LANE_BITS;
  localparam int ADDR_W     = 18;
  localparam int BURST_W    = 2;

  // ----------------------------------------------------------------
  // pipeline timing in clock edges after the command edge
  // ----------------------------------------------------------------
  localparam int WR_DATA_EDGE = 3;          // double late write
  localparam int RD_DATA_EDGE = 1;          // pipelined read

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_RST = 2'h0;

  typedef enum logic [1:0] {
    SBSPC_IDLE  = 2'b00,
    SBSPC_READ  = 2'b01,
    SBSPC_WRITE = 2'b10
  } sbspc_op_t;

endpackage : sbspc_pkg

// ---- common/sbspc_burst_if.sv ----
// carrier between the port control and its burst address generator
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface sbspc_burst_if;
  import sbspc_pkg::*;
  logic               load;       // take a new start value
  logic               advance;    // step the burst
  logic               linear;     // linear order when high
  logic [BURST_W-1:0] start;      // low address bits at load
  logic [BURST_W-1:0] addr;       // low address bits of this access
  modport ctrl (output load, output advance, output linear,
                output start, input addr);
  modport gen  (input load, input advance, input linear,
                input start, output addr);
endinterface : sbspc_burst_if

// ---- rtl/sbspc_burst_gen.sv ----
// two-bit burst address generator, interleaved or linear order
// assumes load and advance never both high
`timescale 1ns/1ps
module sbspc_burst_gen
  import sbspc_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   srst,
  // burst carrier
  sbspc_burst_if.gen  bif
);

  logic [BURST_W-1:0] start_q;
  logic [BURST_W-1:0] step_q;

  // ----------------------------------------------------------------
  // start value and step count
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      start_q <= BURST_RST;
      step_q  <= BURST_RST;
    end else if (bif.load) begin
      start_q <= bif.start;
      // the first advance must already use step one, so count from one
      step_q  <= 2'h1;
    end else if (bif.advance) begin
      step_q  <= step_q + 2'h1;              // wraps after four
    end
  end

  // the address is combinational so the access uses it in the same edge
  always_comb begin
    if (bif.linear) begin
      bif.addr = start_q + step_q;
    end else begin
      bif.addr = start_q ^ step_q;
    end
  end

endmodule : sbspc_burst_gen

// ---- test/sbspc_ctl_model.sv ----
// far-side memory controller model driving the sram command pins
// assumes one clock; the bench calls burst() and keeps expectations
`timescale 1ns/1ps
module sbspc_ctl_model
  import sbspc_pkg::*;
(
  // clock and straps
  input  wire logic              sys_clk,
  input  wire logic              pol2,
  input  wire logic              pol3,
  // read return
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  input  wire logic              echo_oe,
  // command and write data
  output logic      [7:0]        addr,
  output logic                   load_advance_n,
  output logic                   rw_n,
  output logic                   primary_select_n,
  output logic                   prog_select_two,
  output logic                   prog_select_three,
  output logic      [LANES-1:0]  lane_write_n,
  output logic      [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] rd [4];  // read beats as seen
  logic              ov [4];  // output enable per beat
  logic              eo [4];  // echo enable per beat
  // time zero: a deselect load, so nothing starts before the bench asks
  initial begin
    {addr, rw_n, prog_select_two, prog_select_three} = '0;
    {load_advance_n, lane_write_n, data_in} = '0;
    primary_select_n = 1'b1;
  end
  // load, advances, then deselect loads until the last late write lands
  task automatic burst(input logic w, input logic [7:0] a,
                       input logic [7:0] be, input logic [1:0] dsel,
                       input logic [DATA_W-1:0] d [4], input int n);
    for (int i = 0; i < n + 3; i++) begin
      @(posedge sys_clk);
      #1;
      if (i >= 2 && i < n + 2) begin
        rd[i-2] = data_out;
        ov[i-2] = data_oe;
        eo[i-2] = echo_oe;
      end
      load_advance_n    = i > 0 && i < n;
      rw_n              = i == 0 ? !w : w;
      primary_select_n  = i == 0 ? dsel[0] : 1'b1;
      prog_select_two   = pol2 ^ (i > 0 || dsel[1]);
      prog_select_three = pol3;
      // junk address on advances: the latched one must win
      addr              = i == 0 ? a : 8'($urandom);
      lane_write_n      = i < n ? be : 8'($urandom);
      // data toggles away from the capture edge so a slip shows
      data_in           = i >= 3 ? d[i-3] : ~data_in;
    end
  endtask : burst
endmodule : sbspc_ctl_model

// ---- test/sbspc_port_ctrl_tb_top.sv ----
// random burst testbench for the sram port control
// assumes a reduced depth of 256 words and a reference array here
`timescale 1ns/1ps
module sbspc_port_ctrl_tb_top
  import sbspc_pkg::*;
;
  logic              sys_clk, srst, pol2, pol3, order_n, lan, rw_n;
  logic              ps_n, s2, s3, doe, t1, t2, v1, v2, eoe;
  logic [7:0]        addr, bwn;
  logic [DATA_W-1:0] din, dout;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] d [4];
  int                failures, checks;

  sbspc_port_ctrl #(.DEPTH_W(8)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .addr(addr), .load_advance_n(lan),
    .rw_n(rw_n), .primary_select_n(ps_n), .prog_select_two(s2),
    .prog_select_three(s3), .lane_write_n(bwn),
    .select_two_polarity(pol2), .select_three_polarity(pol3),
    .burst_order_sel_n(order_n), .data_in(din), .data_out(dout),
    .data_oe(doe), .echo_clock_true_one(t1), .echo_clock_true_two(t2),
    .echo_clock_inv_one(v1), .echo_clock_inv_two(v2), .echo_oe(eoe));
  sbspc_ctl_model i_ctl (
    .sys_clk(sys_clk), .pol2(pol2), .pol3(pol3), .data_out(dout),
    .data_oe(doe), .echo_oe(eoe), .addr(addr), .load_advance_n(lan),
    .rw_n(rw_n),
    .primary_select_n(ps_n), .prog_select_two(s2),
    .prog_select_three(s3), .lane_write_n(bwn), .data_in(din));

  // --------------------------------------------------------------
  // expectation helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] baddr(logic [7:0] a, int k, logic lin);
    return {a[7:2], lin ? 2'(a[1:0] + k) : 2'(a[1:0] ^ k)};
  endfunction : baddr
  // only lanes with a low enable take the new nine bits
  function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o,
                                              logic [DATA_W-1:0] n,
                                              logic [7:0] be);
    for (int j = 0; j < LANES; j++) begin
      if (!be[j]) o[9*j +: 9] = n[9*j +: 9];
    end
    return o;
  endfunction : merge
  task automatic chk(input logic [DATA_W-1:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wrap_up();
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // one burst, then fold writes into the array and judge reads
  task automatic run(input logic w, input logic [7:0] a, be,
                     input logic [1:0] dsel, input int n);
    logic [7:0] ea;
    for (int k = 0; k < 4; k++) d[k] = DATA_W'({$urandom, $urandom,
                                                $urandom});
    i_ctl.burst(w, a, be, dsel, d, n);
    // the task returns just after a rising edge: true high, inverted low
    chk({t1, t2, v1, v2}, 4'hC);
    for (int k = 0; k < n; k++) begin
      ea = baddr(a, k, !order_n);
      if (w && dsel == 2'h0) mem[ea] = merge(mem[ea], d[k], be);
      if (!w) chk(i_ctl.ov[k], dsel == 2'h0);
      chk(i_ctl.eo[k], !dsel[1]);
      if (!w && dsel == 2'h0) chk(i_ctl.rd[k], mem[ea]);
    end
  endtask : run

  // --------------------------------------------------------------
  // clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // a hang is cut short after 100k cycles
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    {failures, checks} = '0;
    {srst, pol2, pol3, order_n} = 4'hB;
    void'($urandom(32'h7B30));
    repeat (10) @(posedge sys_clk);
    #1 srst = 1'b0;
    // full-word fill so no read ever meets an unwritten word
    for (int a = 0; a < 256; a += 4) run(1'b1, 8'(a), 8'h00, 2'h0, 4);
    // partial lanes, linear wrap from the top slot, then read back
    order_n = 1'b0;
    for (int j = 0; j < 2; j++) run(j == 0, 8'h47, 8'h5A, 2'h0, 4);
    // random mix of straps, lanes, lengths and deselects
    for (int j = 0; j < 300; j++) begin
      {order_n, pol2, pol3} = 3'($urandom);
      run(1'($urandom), 8'($urandom), j % 7 ? 8'($urandom) : 8'h00,
          $urandom % 4 ? 2'h0 : 2'($urandom_range(1, 3)),
          $urandom_range(1, 4));
    end
    wrap_up();
  end
endmodule : sbspc_port_ctrl_tb_top
